//--- rtl/trip_seq_pkg.sv
// Shared constants and types of the trip output sequencer.
// Assumes a 125 MHz system clock; all timing below derives from it.
package trip_seq_pkg;

    // ---------------------------------------------------------------
    // Clock and sampling tick
    // ---------------------------------------------------------------
    localparam int CLK_FREQ_HZ      = 125_000_000;
    localparam int TICK_PERIOD_US   = 1000;
    localparam int TICK_CYCLES      = (CLK_FREQ_HZ / 1_000_000) * TICK_PERIOD_US;
    localparam int TICK_CNT_W       = $clog2(TICK_CYCLES);

    // ---------------------------------------------------------------
    // Preparation timeout and trip stretching, in sampling ticks
    // ---------------------------------------------------------------
    localparam int PREP_TIMEOUT_MS  = 50;
    localparam int TICK_PERIOD_MS   = TICK_PERIOD_US / 1000;
    localparam int PREP_TIMEOUT_TICKS = PREP_TIMEOUT_MS / TICK_PERIOD_MS;
    localparam int PREP_TMR_W       = 6;
    localparam int MIN_TRIP_MS      = 100;
    localparam int MIN_TRIP_TICKS   = MIN_TRIP_MS / TICK_PERIOD_MS;
    localparam int STRETCH_W        = 16;

    // ---------------------------------------------------------------
    // Channel geometry and reset values
    // ---------------------------------------------------------------
    localparam int NUM_CHANNELS     = 4;
    localparam int NUM_PHASES       = 3;
    localparam logic RST_OPEN       = 1'h0;

    // States of one trip channel.
    typedef enum logic [1:0] {
        CH_IDLE,
        CH_ARMED,
        CH_FIRED,
        CH_RELEASE
    } chan_state_t;

endpackage

//--- rtl/trip_tick_if.sv
// Carries the sampling tick and the shaped phase trips between the
// sequencer's own modules.
// Assumes a single clock domain.
`timescale 1ns/100ps
interface trip_tick_if;
    import trip_seq_pkg::*;

    logic                  tick;
    logic                  eval;
    logic [NUM_PHASES-1:0] shaped;

    modport timer  (output tick, output eval);
    modport shaper (input tick, output shaped);
    modport seq    (input eval, input shaped);
endinterface

//--- rtl/sample_tick_gen.sv
// Sampling tick generator: one pulse per sampling period, plus a
// second pulse one clock later for logic that consumes shaped trips.
// Assumes clk at the package rate and rst_b asynchronous, active low.
`timescale 1ns/100ps
module sample_tick_gen #(
    parameter int TICK_CYCLES = trip_seq_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic  clk,
    input  wire logic  rst_b,
    // Tick outputs
    trip_tick_if.timer tk
);
    import trip_seq_pkg::*;

    localparam int                W    = $clog2(TICK_CYCLES + 1);
    localparam logic [W-1:0]      LAST = W'(TICK_CYCLES - 1);

    logic [W-1:0] cnt_q;
    logic         tick_q;
    logic         eval_q;

    // Free running divider of the system clock.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= '0;
        end else if (cnt_q == LAST) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // Tick pulse and its one-cycle delayed evaluation strobe.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tick_q <= 1'h0;
            eval_q <= 1'h0;
        end else begin
            tick_q <= (cnt_q == LAST);
            eval_q <= tick_q;
        end
    end

    assign tk.tick = tick_q;
    assign tk.eval = eval_q;
endmodule

//--- rtl/trip_shaper.sv
// Trip shaping stage: widens phase-to-phase trips to three-phase and
// holds every phase trip for a minimum number of sampling ticks.
// Assumes inputs synchronous to clk and a tick from sample_tick_gen.
`timescale 1ns/100ps
module trip_shaper #(
    parameter int MIN_TRIP_TICKS = trip_seq_pkg::MIN_TRIP_TICKS
) (
    // Clock and reset
    input  wire logic                                clk,
    input  wire logic                                rst_b,
    // Raw trip requests
    input  wire logic [trip_seq_pkg::NUM_PHASES-1:0] trip_phase,
    input  wire logic                                trip_3ph,
    input  wire logic                                conv_3ph_en,
    // Tick in, shaped trips out
    trip_tick_if.shaper                              tk
);
    import trip_seq_pkg::*;

    localparam logic [STRETCH_W-1:0] HOLD = STRETCH_W'(MIN_TRIP_TICKS);

    logic [NUM_PHASES-1:0] widened;
    logic [NUM_PHASES-1:0] shaped_q;
    logic                  multi_phase;

    // Two or more phases raised means a phase-to-phase fault.
    always_comb begin
        multi_phase = (trip_phase[0] & trip_phase[1]) | (trip_phase[1] & trip_phase[2])
                    | (trip_phase[0] & trip_phase[2]);
        if (trip_3ph || (conv_3ph_en && multi_phase)) begin
            widened = '1;
        end else begin
            widened = trip_phase;
        end
    end

    // One stretch counter per phase, updated only on sampling ticks.
    for (genvar p = 0; p < NUM_PHASES; p++) begin : g_phase
        logic [STRETCH_W-1:0] hold_q;

        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                hold_q      <= '0;
                shaped_q[p] <= RST_OPEN;
            end else if (tk.tick) begin
                if (widened[p]) begin
                    hold_q      <= HOLD;
                    shaped_q[p] <= 1'h1;
                end else if (hold_q > STRETCH_W'(1)) begin
                    hold_q      <= hold_q - 1'b1;
                    shaped_q[p] <= 1'h1;
                end else begin
                    hold_q      <= '0;
                    shaped_q[p] <= 1'h0;
                end
            end
        end
    end

    assign tk.shaped = shaped_q;
endmodule

//--- rtl/trip_output_sequencer.sv
// Trip output sequencer: drives the mechanical contact and the fast
// electronic switch of each trip channel of a protection relay.
// Assumes all inputs synchronous to clk; contacts follow the outputs.
`timescale 1ns/100ps
module trip_output_sequencer #(
    parameter int NUM_CH         = trip_seq_pkg::NUM_CHANNELS,
    parameter int TICK_CYCLES    = trip_seq_pkg::TICK_CYCLES,
    parameter int MIN_TRIP_TICKS = trip_seq_pkg::MIN_TRIP_TICKS
) (
    // Clock and reset
    input  wire logic                                     clk,
    input  wire logic                                     rst_b,
    // Protection pickup, one per channel
    input  wire logic [NUM_CH-1:0]                        prep_req,
    // Protection trips into the shaping stage
    input  wire logic [trip_seq_pkg::NUM_PHASES-1:0]      prot_trip_phase,
    input  wire logic                                     prot_trip_3ph,
    input  wire logic                                     conv_3ph_en,
    // Shaper output to channel map, three bits per channel
    input  wire logic [NUM_CH*trip_seq_pkg::NUM_PHASES-1:0] assign_map,
    // Direct trip sources, one per channel
    input  wire logic [NUM_CH-1:0]                        link_trip,
    input  wire logic [NUM_CH-1:0]                        panel_trip,
    input  wire logic [NUM_CH-1:0]                        binary_trip,
    input  wire logic [NUM_CH-1:0]                        per_cycle_fast_contact,
    // Channel drive
    output logic      [NUM_CH-1:0]                        mech_close_q,
    output logic      [NUM_CH-1:0]                        elec_close_q,
    output logic      [NUM_CH-1:0]                        coil_on_q,
    // Channel status
    output logic      [NUM_CH-1:0]                        armed_q,
    output logic      [NUM_CH-1:0]                        prep_cancel_q,
    output logic      [trip_seq_pkg::NUM_PHASES-1:0]      shaped_trip_q
);
    import trip_seq_pkg::*;

    localparam logic [PREP_TMR_W-1:0] PREP_LAST = PREP_TMR_W'(PREP_TIMEOUT_TICKS - 1);

    // ---------------------------------------------------------------
    // Sampling tick and trip shaping
    // ---------------------------------------------------------------

    trip_tick_if tk ();

    // One sampling tick per period; eval follows tick by one clock so
    // that channels see the shaped trips of the same sampling period.
    sample_tick_gen #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .clk   (clk),
        .rst_b (rst_b),
        .tk    (tk)
    );

    // Phase widening and minimum duration stretch.
    trip_shaper #(
        .MIN_TRIP_TICKS (MIN_TRIP_TICKS)
    ) u_shaper (
        .clk         (clk),
        .rst_b       (rst_b),
        .trip_phase  (prot_trip_phase),
        .trip_3ph    (prot_trip_3ph),
        .conv_3ph_en (conv_3ph_en),
        .tk          (tk)
    );

    assign shaped_trip_q = tk.shaped;

    // ---------------------------------------------------------------
    // Per channel sequencing
    // ---------------------------------------------------------------

    for (genvar c = 0; c < NUM_CH; c++) begin : g_chan
        chan_state_t             state_q;
        chan_state_t             state_d;
        logic [PREP_TMR_W-1:0]   tmr_q;
        logic [NUM_PHASES-1:0]   map;
        logic                    shaped_hit;
        logic                    trip_req;
        logic                    cancel_d;

        // Freely chosen subset of shaper phases feeds this channel.
        assign map        = assign_map[c*NUM_PHASES +: NUM_PHASES];
        assign shaped_hit = |(map & tk.shaped);

        // Every trip source of the channel meets in one OR gate.
        assign trip_req = shaped_hit | link_trip[c] | panel_trip[c]
                        | binary_trip[c] | per_cycle_fast_contact[c];

        // Next channel state, only meaningful on an evaluation strobe.
        always_comb begin
            state_d  = state_q;
            cancel_d = 1'h0;
            unique case (state_q)
                CH_IDLE: begin
                    if (trip_req) begin
                        // Fast contact and direct sources close both
                        // elements in one step.
                        state_d = CH_FIRED;
                    end else if (prep_req[c]) begin
                        state_d = CH_ARMED;
                    end
                end
                CH_ARMED: begin
                    if (trip_req) begin
                        state_d = CH_FIRED;
                    end else if (tmr_q == PREP_LAST) begin
                        state_d  = CH_IDLE;
                        cancel_d = 1'h1;
                    end
                end
                CH_FIRED: begin
                    if (!trip_req) begin
                        state_d = CH_RELEASE;
                    end
                end
                CH_RELEASE: begin
                    // Switch is open already; contact opens a tick later.
                    state_d = CH_IDLE;
                end
            endcase
        end

        // State advances only on the per-tick evaluation strobe.
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                state_q <= CH_IDLE;
            end else if (tk.eval) begin
                state_q <= state_d;
            end
        end

        // Ticks spent armed, restarted at each arming.
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                tmr_q <= '0;
            end else if (tk.eval) begin
                if (state_q == CH_ARMED && state_d == CH_ARMED) begin
                    tmr_q <= tmr_q + 1'b1;
                end else begin
                    tmr_q <= '0;
                end
            end
        end

        // Contact drive registered from the next state; the coil sees
        // current only while both series elements are closed.
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                mech_close_q[c] <= RST_OPEN;
                elec_close_q[c] <= RST_OPEN;
                coil_on_q[c]    <= RST_OPEN;
                armed_q[c]      <= 1'h0;
            end else if (tk.eval) begin
                mech_close_q[c] <= (state_d != CH_IDLE);
                elec_close_q[c] <= (state_d == CH_FIRED);
                coil_on_q[c]    <= (state_d == CH_FIRED);
                armed_q[c]      <= (state_d == CH_ARMED);
            end
        end

        // One clock pulse marking a timed-out preparation.
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                prep_cancel_q[c] <= 1'h0;
            end else begin
                prep_cancel_q[c] <= tk.eval & cancel_d;
            end
        end
    end

endmodule

//--- testbench/trip_output_sequencer_asserts.sv
// Port-level checks of the trip output sequencer.
// Assumes it is bound to each sequencer and shares its parameters.
`timescale 1ns/100ps
module trip_output_sequencer_asserts #(
    parameter int NUM_CH         = 4,
    parameter int TICK_CYCLES    = 20,
    parameter int MIN_TRIP_TICKS = 3
) (
    // Clock and reset
    input wire logic                                       clk,
    input wire logic                                       rst_b,
    // Requests
    input wire logic [NUM_CH-1:0]                          prep_req,
    input wire logic [trip_seq_pkg::NUM_PHASES-1:0]        prot_trip_phase,
    input wire logic                                       prot_trip_3ph,
    input wire logic                                       conv_3ph_en,
    input wire logic [NUM_CH*trip_seq_pkg::NUM_PHASES-1:0] assign_map,
    input wire logic [NUM_CH-1:0]                          link_trip,
    input wire logic [NUM_CH-1:0]                          panel_trip,
    input wire logic [NUM_CH-1:0]                          binary_trip,
    input wire logic [NUM_CH-1:0]                          per_cycle_fast_contact,
    // Channel outputs
    input wire logic [NUM_CH-1:0]                          mech_close_q,
    input wire logic [NUM_CH-1:0]                          elec_close_q,
    input wire logic [NUM_CH-1:0]                          coil_on_q,
    input wire logic [NUM_CH-1:0]                          armed_q,
    input wire logic [NUM_CH-1:0]                          prep_cancel_q,
    input wire logic [trip_seq_pkg::NUM_PHASES-1:0]        shaped_trip_q
);
    localparam int REL_HOLD     = TICK_CYCLES - 1;
    localparam int SRC_SPAN     = 2 * TICK_CYCLES;
    localparam int CANCEL_SPAN  = 50 * TICK_CYCLES;
    localparam int STRETCH_SPAN = MIN_TRIP_TICKS * TICK_CYCLES;
    logic [15:0] arm_cnt_q;
    logic [15:0] src_cnt_q;
    logic [15:0] sh_cnt_q;
    wire         src0 = link_trip[0] | panel_trip[0] | binary_trip[0] | per_cycle_fast_contact[0];
    // Counters for holds too long for a repetition.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            arm_cnt_q <= 16'h0;
            src_cnt_q <= 16'h0;
            sh_cnt_q  <= 16'h0;
        end else begin
            arm_cnt_q <= armed_q[0] ? arm_cnt_q + 16'h1 : 16'h0;
            src_cnt_q <= src0 ? src_cnt_q + 16'h1 : 16'h0;
            sh_cnt_q  <= shaped_trip_q[0] ? sh_cnt_q + 16'h1 : 16'h0;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Switch opens first, the contact one tick later.
    sequence release_s;
        mech_close_q[0] ##REL_HOLD mech_close_q[0] ##1 !mech_close_q[0];
    endsequence
    coil_both_a: assert property (coil_on_q == (mech_close_q & elec_close_q))
        else $error("coil differs from contact pair");
    switch_order_a: assert property ((elec_close_q & ~mech_close_q) == '0)
        else $error("switch closed with contact open");
    arm_cause_a: assert property ($rose(armed_q[0]) |-> $past(prep_req[0]) && mech_close_q[0] && !elec_close_q[0])
        else $error("arming without pickup");
    fire_cause_a: assert property ($rose(elec_close_q[0]) |-> $past(src0 | (|(shaped_trip_q & assign_map[2:0]))))
        else $error("switch closed without trip");
    cancel_time_a: assert property (prep_cancel_q[0] |-> arm_cnt_q == CANCEL_SPAN && !mech_close_q[0] ##1 !prep_cancel_q[0])
        else $error("cancel timing wrong");
    tick_pace_a: assert property ($changed(mech_close_q) |=> $stable(mech_close_q)[*8])
        else $error("contact changed between ticks");
    widen_all_a: assert property ($changed(shaped_trip_q) && ($past(prot_trip_3ph) ||
        $past(conv_3ph_en) && $countones($past(prot_trip_phase)) > 1) |-> &shaped_trip_q)
        else $error("trip not widened");
    stretch_min_a: assert property ($fell(shaped_trip_q[0]) |-> sh_cnt_q >= STRETCH_SPAN)
        else $error("trip too short");
    source_fire_a: assert property (src_cnt_q >= SRC_SPAN |-> elec_close_q[0])
        else $error("direct source ignored");
    release_seq_a: assert property ($fell(elec_close_q[0]) |-> release_s)
        else $error("release order wrong");
endmodule

bind trip_output_sequencer trip_output_sequencer_asserts #(
    .NUM_CH(NUM_CH), .TICK_CYCLES(TICK_CYCLES), .MIN_TRIP_TICKS(MIN_TRIP_TICKS)
) u_chk (.*);

//--- testbench/breaker_coil_model.sv
// Breaker trip coil behind each channel's contact pair.
// Assumes it sees the sequencer's contact drive outputs.
`timescale 1ns/100ps
module breaker_coil_model #(
    parameter int N = 4
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_b,
    // Contact pair per channel
    input  wire logic [N-1:0] mech_closed,
    input  wire logic [N-1:0] elec_closed,
    // Coil state
    output logic      [N-1:0] energised,
    output logic      [N-1:0] arc_q
);
    logic [N-1:0] en_q;
    // Current flows only through both series elements.
    assign energised = mech_closed & elec_closed;
    // Opening the contact under current burns it; latch that.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            en_q  <= '0;
            arc_q <= '0;
        end else begin
            en_q  <= energised;
            arc_q <= arc_q | (en_q & ~mech_closed) | (elec_closed & ~mech_closed);
        end
    end
endmodule

//--- testbench/trip_output_sequencer_tb.sv
// Self-checking bench of the trip output sequencer.
// Assumes the checker binds itself and the coil model is compiled.
`timescale 1ns/100ps
module trip_output_sequencer_tb;
    localparam int T = 20;
    localparam int M = 3;
    localparam logic [4:0] TBL [4] = '{5'h09, 5'h03, 5'h0D, 5'h12};
    logic        clk = 1'h0;
    logic        rst_b = 1'h0;
    logic [3:0]  prep_req = 4'h0;
    logic [15:0] srcs = 16'h0;
    logic [2:0]  prot_trip_phase = 3'h0;
    logic        prot_trip_3ph = 1'h0;
    logic        conv_3ph_en = 1'h0;
    logic [11:0] assign_map = 12'h0;
    logic [3:0]  mech_close_q, elec_close_q, coil_on_q, armed_q, prep_cancel_q, energised, arc_q;
    logic [2:0]  shaped_trip_q, exp_sh;
    logic [15:0] rnd = 16'hB588;
    logic [4:0]  cs;
    int          failures = 0;
    int          samples_checked = 0;
    int          n, c, k;

    always #4 clk = ~clk;

    trip_output_sequencer #(.NUM_CH(4), .TICK_CYCLES(T), .MIN_TRIP_TICKS(M)) u_dut (
        .clk(clk), .rst_b(rst_b), .prep_req(prep_req), .prot_trip_phase(prot_trip_phase),
        .prot_trip_3ph(prot_trip_3ph), .conv_3ph_en(conv_3ph_en), .assign_map(assign_map),
        .link_trip(srcs[3:0]), .panel_trip(srcs[7:4]), .binary_trip(srcs[11:8]),
        .per_cycle_fast_contact(srcs[15:12]), .mech_close_q(mech_close_q),
        .elec_close_q(elec_close_q), .coil_on_q(coil_on_q), .armed_q(armed_q),
        .prep_cancel_q(prep_cancel_q), .shaped_trip_q(shaped_trip_q));

    breaker_coil_model #(.N(4)) u_coil (
        .clk(clk), .rst_b(rst_b), .mech_closed(mech_close_q), .elec_closed(elec_close_q),
        .energised(energised), .arc_q(arc_q));

    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    function automatic logic [2:0] widen(input logic [2:0] ph, input logic all3, input logic cv);
        return (all3 || (cv && $countones(ph) > 1)) ? 3'h7 : ph;
    endfunction
    function automatic logic [3:0] fires(input logic [11:0] map, input logic [2:0] sh);
        for (int i = 0; i < 4; i++) fires[i] = |(map[3*i +: 3] & sh);
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("compared %0d, mismatched %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic give_up(input int cnt, input int lim);
        if (cnt >= lim) begin
            failures++;
            $display("ERROR at %0t: wait ran out", $time);
            end_of_test();
        end
    endtask

    // Main sequence: arming timeout, armed trip, direct sources, shaper.
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'h1;
        @(negedge clk);
        chk({mech_close_q, elec_close_q, coil_on_q, armed_q, prep_cancel_q}, 32'h0);
        @(posedge clk);
        prep_req <= 4'h1;
        for (n = 0; n < 3 * T && !armed_q[0]; n++) @(negedge clk);
        give_up(n, 3 * T);
        chk({mech_close_q[0], elec_close_q[0]}, 32'h2);
        for (n = 0; n < 60 * T && !prep_cancel_q[0]; n++) @(negedge clk);
        give_up(n, 60 * T);
        chk(n, 50 * T);
        chk(mech_close_q[0], 32'h0);
        $display("timeout test done");
        for (n = 0; n < 2 * T && !armed_q[0]; n++) @(negedge clk);
        give_up(n, 2 * T);
        @(posedge clk);
        prep_req <= 4'h0;
        srcs     <= 16'h1;
        for (n = 0; n < 2 * T && !elec_close_q[0]; n++) @(negedge clk);
        give_up(n, 2 * T);
        chk({mech_close_q[0], coil_on_q[0], energised[0]}, 32'h7);
        repeat (2 * T) @(posedge clk);
        srcs <= 16'h0;
        for (n = 0; n < 2 * T && elec_close_q[0]; n++) @(negedge clk);
        give_up(n, 2 * T);
        for (n = 0; n < 2 * T && mech_close_q[0]; n++) @(negedge clk);
        chk(n, T);
        $display("armed trip test done");
        for (k = 0; k < 8; k++) begin
            rnd = lfsr(rnd);
            c = rnd[1:0];
            @(posedge clk);
            srcs <= 16'h1 << (4 * (k % 4) + c);
            for (n = 0; n < T + 2 && !coil_on_q[c]; n++) @(negedge clk);
            give_up(n, T + 2);
            chk(coil_on_q, 4'h1 << c);
            @(posedge clk);
            srcs <= 16'h0;
            for (n = 0; n < 3 * T && mech_close_q != 4'h0; n++) @(negedge clk);
            give_up(n, 3 * T);
            $display("source test %0d done", k);
        end
        for (k = 0; k < 8; k++) begin
            rnd = lfsr(rnd);
            cs = (k < 4) ? TBL[k] : {rnd[15:14], rnd[13:11] | 3'h4};
            exp_sh = widen(cs[2:0], cs[4], cs[3]);
            @(posedge clk);
            assign_map      <= rnd[11:0];
            prot_trip_phase <= cs[2:0];
            conv_3ph_en     <= cs[3];
            prot_trip_3ph   <= cs[4];
            for (n = 0; n < T + 2 && shaped_trip_q == 3'h0; n++) @(negedge clk);
            give_up(n, T + 2);
            chk(shaped_trip_q, exp_sh);
            @(posedge clk);
            prot_trip_phase <= 3'h0;
            prot_trip_3ph   <= 1'h0;
            @(negedge clk);
            chk(elec_close_q, fires(assign_map, exp_sh));
            for (n = 0; n < M * T + 2 && shaped_trip_q != 3'h0; n++) @(negedge clk);
            chk(n, M * T - 1);
            for (n = 0; n < 3 * T && mech_close_q != 4'h0; n++) @(negedge clk);
            give_up(n, 3 * T);
            $display("shaper test %0d done", k);
        end
        chk(arc_q, 32'h0);
        end_of_test();
    end
endmodule
